//--- rfsmf_pkg.sv
// rfsmf_pkg: constants and types for the receive frame status and
// group address hash filter block.
// assumes an apb host with 32-bit data and 12-bit byte addresses.
package rfsmf_pkg;

	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 16;

	// register banks, each register one word at base + 4 * index
	localparam logic [11:0] BANK_RX = 12'h000;
	localparam logic [11:0] BANK_HASH = 12'h100;
	localparam logic [11:0] BANK_CTRL = 12'h200;

	// printed register indices
	localparam logic [7:0] IDX_STATUS = 8'h04;
	localparam logic [7:0] IDX_BYTE_COUNT = 8'h06;
	localparam logic [7:0] IDX_HASH0 = 8'h00;
	localparam logic [7:0] IDX_HASH1 = 8'h02;
	localparam logic [7:0] IDX_HASH2 = 8'h04;
	localparam logic [7:0] IDX_HASH3 = 8'h06;
	localparam logic [7:0] IDX_RX_CTRL = 8'h00;
	localparam logic [7:0] IDX_RELEASE = 8'h02;

	localparam logic [11:0] ADDR_STATUS = BANK_RX + {2'h0, IDX_STATUS, 2'h0};
	localparam logic [11:0] ADDR_BYTE_COUNT =
		BANK_RX + {2'h0, IDX_BYTE_COUNT, 2'h0};
	localparam logic [11:0] ADDR_HASH0 = BANK_HASH + {2'h0, IDX_HASH0, 2'h0};
	localparam logic [11:0] ADDR_HASH1 = BANK_HASH + {2'h0, IDX_HASH1, 2'h0};
	localparam logic [11:0] ADDR_HASH2 = BANK_HASH + {2'h0, IDX_HASH2, 2'h0};
	localparam logic [11:0] ADDR_HASH3 = BANK_HASH + {2'h0, IDX_HASH3, 2'h0};
	localparam logic [11:0] ADDR_RX_CTRL =
		BANK_CTRL + {2'h0, IDX_RX_CTRL, 2'h0};
	localparam logic [11:0] ADDR_RELEASE =
		BANK_CTRL + {2'h0, IDX_RELEASE, 2'h0};

	// status word fields
	localparam int ST_VALID = 15;
	localparam int ST_PORT_HI = 9;
	localparam int ST_PORT_LO = 8;
	localparam int ST_BCAST = 7;
	localparam int ST_MCAST = 6;
	localparam int ST_UCAST = 5;
	localparam int ST_TYPE = 3;
	localparam int ST_LONG = 2;
	localparam int ST_RUNT = 1;
	localparam int ST_FCS = 0;

	// receive control fields
	localparam int CTL_ALL_FRAMES = 4;
	localparam int CTL_ALL_GROUP = 5;
	localparam int CTL_PASS_BAD = 9;
	localparam int REL_BIT = 0;

	// reset values
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] HASH_RESET = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0000;

	// frame classification
	localparam int BYTE_COUNT_W = 11;
	localparam logic [10:0] MAX_FRAME_BYTES = 11'h77c;
	localparam logic [15:0] LEN_TYPE_MAX = 16'h05dc;
	localparam logic [1:0] PORT_ONE = 2'h1;
	localparam logic [1:0] PORT_TWO = 2'h2;
	localparam logic [47:0] BCAST_DA = 48'hffff_ffff_ffff;
	localparam int IG_BIT = 40;

	// hash
	localparam int HASH_W = 6;
	localparam int DA_W = 48;
	localparam int HASH_WORDS = 4;
	localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
	localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

	// completed frame offered by the receive mac
	typedef struct packed {
		logic [47:0] da;
		logic [15:0] len_type;
		logic [10:0] byte_count;
		logic [1:0] port;
		logic runt;
		logic fcs_err;
	} rfsmf_frame_type;

endpackage : rfsmf_pkg

//--- rfsmf_core.sv
// rfsmf_core: head-of-queue receive frame status, byte count and
// group address hash filtering, reached as an apb slave.
// assumes frames arrive from same-clock mac logic with valid/ready.
//
// What this block does
// - frame valid bit set once head frame fully received and status held
// - frame valid bit clear while no frame is pending at the head
// - source port field encodes 01 for port one, 10 for port two
// - broadcast flag set for the all-ones destination address
// - group flag set for any group address, broadcast included
// - individual flag set for an individual destination address
// - type flag set when length/type exceeds 1500, not for runts
// - overlength flag set when frame exceeds 1916 bytes
// - overlength frames are never truncated, full count kept
// - bad frames reach host only with pass bad frame bit set
// - short frame flag set for collision damaged or cut off frames
// - fcs error flag set when frame check sequence fails
// - read-only status register mirrors the head frame status word
// - byte count register shows 11-bit count, upper bits read zero
// - crc over destination address, top six bits index a 64-bit table
// - top two hash bits pick the word, low four pick the bit
// - group frame accepted when its table bit is set
// - group frame other than broadcast dropped when its table bit is clear
// - accept-all or accept-all-group bits accept every group frame not dropped as bad
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
module rfsmf_core
	import rfsmf_pkg::*;
(
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic [DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// completed frames from the receive mac
	input wire logic frm_valid,
	input wire rfsmf_frame_type frm,
	output logic frm_ready,
	// per-frame outcome pulses
	output logic frm_accept,
	output logic frm_drop
);

	// ethernet crc-32 over the destination address, first byte lsb first
	// standard crc-32 hash
	function automatic logic [HASH_W-1:0] da_hash(input logic [47:0] da);
		logic [31:0] crc;
		logic fb;
		crc = CRC_INIT;
		fb = 1'b0;
		for (int i = 0; i < DA_W; i++) begin
			fb = crc[31] ^ da[DA_W - 8 - 8 * (i / 8) + (i % 8)];
			crc = {crc[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
		end
		return crc[31:32-HASH_W];
	endfunction : da_hash

	// register state
	logic [REG_W-1:0] rx_ctrl;
	logic [REG_W-1:0] hash_tbl [HASH_WORDS];
	logic [REG_W-1:0] head_status;
	logic [BYTE_COUNT_W-1:0] head_count;
	logic head_valid;
	logic [REG_W-1:0] next_rx_ctrl;
	logic [REG_W-1:0] next_hash_tbl [HASH_WORDS];
	logic [REG_W-1:0] next_head_status;
	logic [BYTE_COUNT_W-1:0] next_head_count;
	logic next_head_valid;
	logic next_frm_ready;
	logic next_frm_accept;
	logic next_frm_drop;
	logic [DATA_W-1:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// classification of the offered frame
	logic take;
	logic is_bcast;
	logic is_group;
	logic is_long;
	logic is_type;
	logic is_bad;
	logic [HASH_W-1:0] hidx;
	logic hash_hit;
	logic promisc;
	logic keep;
	logic [REG_W-1:0] frm_status;

	// apb phases
	logic setup;
	logic done;
	logic wr_done;
	logic addr_ok;
	logic [REG_W-1:0] rd_word;

	assign take = frm_valid && frm_ready;
	assign setup = psel && !penable;
	assign done = psel && penable && pready;
	assign wr_done = done && pwrite;

	always_comb begin
		is_bcast = (frm.da == BCAST_DA);
		is_group = frm.da[IG_BIT];
		is_long = (frm.byte_count > MAX_FRAME_BYTES);
		is_type = !frm.runt && (frm.len_type > LEN_TYPE_MAX);
		is_bad = is_long || frm.runt || frm.fcs_err;
		hidx = da_hash(frm.da);
		hash_hit = hash_tbl[hidx[5:4]][hidx[3:0]];
		promisc = rx_ctrl[CTL_ALL_FRAMES] || rx_ctrl[CTL_ALL_GROUP];
		keep = !(is_bad && !rx_ctrl[CTL_PASS_BAD]) &&
			!(is_group && !is_bcast && !promisc && !hash_hit);
		frm_status = STATUS_RESET;
		frm_status[ST_VALID] = 1'b1;
		frm_status[ST_PORT_HI:ST_PORT_LO] = frm.port;
		frm_status[ST_BCAST] = is_bcast;
		frm_status[ST_MCAST] = is_group;
		frm_status[ST_UCAST] = !is_group;
		frm_status[ST_TYPE] = is_type;
		frm_status[ST_LONG] = is_long;
		frm_status[ST_RUNT] = frm.runt;
		frm_status[ST_FCS] = frm.fcs_err;
	end

	// register decode for reads
	always_comb begin
		addr_ok = 1'b1;
		rd_word = 16'h0000;
		case (paddr)
			// status mirror, valid only while head held
			ADDR_STATUS: rd_word = {head_valid, head_status[ST_VALID-1:0]};
			// count in low bits, rest zero
			ADDR_BYTE_COUNT: rd_word = {5'h00, head_count};
			ADDR_HASH0: rd_word = hash_tbl[0];
			ADDR_HASH1: rd_word = hash_tbl[1];
			ADDR_HASH2: rd_word = hash_tbl[2];
			ADDR_HASH3: rd_word = hash_tbl[3];
			ADDR_RX_CTRL: rd_word = rx_ctrl;
			ADDR_RELEASE: rd_word = 16'h0000;
			default: addr_ok = 1'b0;
		endcase
	end

	// next values
	always_comb begin
		next_rx_ctrl = rx_ctrl;
		next_hash_tbl = hash_tbl;
		next_head_status = head_status;
		next_head_count = head_count;
		next_head_valid = head_valid;
		next_frm_accept = 1'b0;
		next_frm_drop = 1'b0;
		next_prdata = prdata;
		next_pready = pready;
		next_pslverr = pslverr;
		// apb answer one cycle after setup
		if (setup) begin
			next_pready = 1'b1;
			next_pslverr = !addr_ok;
			next_prdata = pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
		end else if (done) begin
			next_pready = 1'b0;
			next_pslverr = 1'b0;
		end
		if (wr_done) begin
			case (paddr)
				ADDR_HASH0: next_hash_tbl[0] = pwdata[REG_W-1:0];
				ADDR_HASH1: next_hash_tbl[1] = pwdata[REG_W-1:0];
				ADDR_HASH2: next_hash_tbl[2] = pwdata[REG_W-1:0];
				ADDR_HASH3: next_hash_tbl[3] = pwdata[REG_W-1:0];
				ADDR_RX_CTRL: next_rx_ctrl = pwdata[REG_W-1:0];
				ADDR_RELEASE: begin
					if (pwdata[REL_BIT])
						next_head_valid = 1'b0;
				end
				default: next_head_valid = next_head_valid;
			endcase
		end
		if (take) begin
			next_frm_accept = keep;
			next_frm_drop = !keep;
			if (keep) begin
				next_head_valid = 1'b1;
				next_head_status = frm_status;
				next_head_count = frm.byte_count;
			end
		end
		next_frm_ready = !next_head_valid;
	end

	// hash table words
	genvar g;
	generate
		for (g = 0; g < HASH_WORDS; g++) begin : g_hash
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					hash_tbl[g] <= HASH_RESET;
				else if (ce)
					hash_tbl[g] <= next_hash_tbl[g];
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_ctrl <= CTRL_RESET;
			head_status <= STATUS_RESET;
			head_count <= 11'h000;
			head_valid <= 1'b0;
			frm_ready <= 1'b0;
			frm_accept <= 1'b0;
			frm_drop <= 1'b0;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			rx_ctrl <= next_rx_ctrl;
			head_status <= next_head_status;
			head_count <= next_head_count;
			head_valid <= next_head_valid;
			frm_ready <= next_frm_ready;
			frm_accept <= next_frm_accept;
			frm_drop <= next_frm_drop;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// checks
	AST_HEAD_LOAD: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && keep |=> head_valid && frm_accept)
		else $error("kept frame did not become valid head");

	AST_VALID_READ: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && setup && !pwrite && paddr == ADDR_STATUS && !head_valid
		|=> prdata[ST_VALID] == 1'b0)
		else $error("status read showed valid with no head frame");

	AST_PORT: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && keep |=> head_status[ST_PORT_HI:ST_PORT_LO] ==
		$past(frm.port))
		else $error("port field differs from ingress port");

	AST_BCAST: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && keep && frm.da == BCAST_DA
		|=> head_status[ST_BCAST] && head_status[ST_MCAST])
		else $error("broadcast frame not flagged broadcast and group");

	AST_UCAST: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && keep |=> head_status[ST_UCAST] ==
		!$past(frm.da[IG_BIT]))
		else $error("individual flag wrong");

	AST_TYPE: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && keep && !frm.runt && frm.len_type > LEN_TYPE_MAX
		|=> head_status[ST_TYPE])
		else $error("type frame not flagged");

	AST_LONG: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && keep && frm.byte_count > MAX_FRAME_BYTES
		|=> head_status[ST_LONG] && head_count ==
		$past(frm.byte_count))
		else $error("overlength frame not flagged or count cut");

	AST_BAD_DROP: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && !rx_ctrl[CTL_PASS_BAD] &&
		(frm.runt || frm.fcs_err) |=> frm_drop && !frm_accept)
		else $error("bad frame passed without pass bad frame bit");

	AST_HASH_DROP: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && is_group && !is_bcast && !promisc && !hash_hit
		|=> frm_drop)
		else $error("group frame kept with clear table bit");

	AST_PROMISC: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && is_group && promisc && !is_bad
		|=> frm_accept)
		else $error("group frame dropped with accept-all set");

	AST_COUNT_READ: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && setup && !pwrite && paddr == ADDR_BYTE_COUNT
		|=> prdata[DATA_W-1:BYTE_COUNT_W] == 21'h0)
		else $error("byte count upper bits not zero");

	AST_HOLD: assert property (@(posedge pclk)
		disable iff (!presetn)
		head_valid && !take |=> $stable(head_status) &&
		$stable(head_count))
		else $error("head status changed without new frame");

	AST_GROUP_FLAG: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && keep |=> head_status[ST_MCAST] ==
		$past(frm.da[IG_BIT]))
		else $error("group flag differs from destination address");

	AST_RUNT: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && keep |=> head_status[ST_RUNT] == $past(frm.runt))
		else $error("short frame flag wrong");

	AST_FCS: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && keep |=> head_status[ST_FCS] == $past(frm.fcs_err))
		else $error("fcs error flag wrong");

	AST_HASH_KEEP: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && take && is_group && !is_bad && hash_hit |=> frm_accept)
		else $error("group frame dropped with set table bit");

	AST_STATUS_READ: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && setup && !pwrite && paddr == ADDR_STATUS |=>
		prdata[REG_W-1:0] == {$past(head_valid),
		$past(head_status[ST_VALID-1:0])})
		else $error("status read differs from head status word");

	AST_RELEASE: assert property (@(posedge pclk)
		disable iff (!presetn)
		ce && wr_done && paddr == ADDR_RELEASE && pwdata[REL_BIT] &&
		head_valid |=> !head_valid && frm_ready)
		else $error("released head frame still valid");

endmodule : rfsmf_core

//--- rfsmf_mac_model.sv
// rfsmf_mac_model: receive mac offering completed frames to the block.
// assumes the block's clock; req pulses for one cycle per frame.
`timescale 1ns/10ps
module rfsmf_mac_model
	import rfsmf_pkg::*;
(
	// clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// bench request
	input wire logic req,
	input wire rfsmf_frame_type req_frm,
	// frame handshake
	input wire logic frm_ready,
	output logic frm_valid,
	output rfsmf_frame_type frm
);
	// offer held until taken on an enabled edge, then the bus is scrambled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frm_valid <= 1'b0;
			frm <= '0;
		end else if (frm_valid && frm_ready && ce) begin
			frm_valid <= 1'b0;
			frm <= ~frm;
		end else if (req) begin
			frm_valid <= 1'b1;
			frm <= req_frm;
		end
	end
endmodule : rfsmf_mac_model

//--- test_rx_frame_status_mcast_filter.sv
// test_rx_frame_status_mcast_filter: self-checking bench for rfsmf_core.
// assumes one head frame at a time, released by the host.
`timescale 1ns/10ps
module test_rx_frame_status_mcast_filter;
	import rfsmf_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, req, err, ce;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic pready, pslverr, frm_valid, frm_ready, frm_accept, frm_drop;
	rfsmf_frame_type frm, req_frm;
	int fail_count, checked;
	logic [47:0] uc = 48'h0200_0000_0001;
	logic [47:0] gc = 48'h0100_5e00_0001;

	rfsmf_core rfsmf_core_i (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .frm_valid(frm_valid), .frm(frm),
		.frm_ready(frm_ready), .frm_accept(frm_accept),
		.frm_drop(frm_drop));
	rfsmf_mac_model rfsmf_mac_model_i (.pclk(pclk), .presetn(presetn),
		.ce(ce), .req(req), .req_frm(req_frm), .frm_ready(frm_ready),
		.frm_valid(frm_valid), .frm(frm));

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task complete_run;
		if (fail_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask : chk

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		chk("pready", 32'h1, {31'h0, pready});
		if (pready !== 1'b1)
			complete_run();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	function automatic rfsmf_frame_type mk(input logic [47:0] da,
		input logic [15:0] lt, input logic [10:0] bc, input logic [1:0] p,
		input logic r, input logic e);
		return {da, lt, bc, p, r, e};
	endfunction : mk

	function automatic logic [15:0] stat(input rfsmf_frame_type f);
		logic [15:0] s;
		s = 16'h0;
		s[ST_VALID] = 1'b1;
		s[ST_PORT_HI:ST_PORT_LO] = f.port;
		s[ST_BCAST] = (f.da == BCAST_DA);
		s[ST_MCAST] = f.da[IG_BIT];
		s[ST_UCAST] = !f.da[IG_BIT];
		s[ST_TYPE] = !f.runt && (f.len_type > LEN_TYPE_MAX);
		s[ST_LONG] = f.byte_count > MAX_FRAME_BYTES;
		s[ST_RUNT] = f.runt;
		s[ST_FCS] = f.fcs_err;
		return s;
	endfunction : stat

	// destination address crc, byte 0 first, each byte lsb first
	function automatic logic [5:0] hash(input logic [47:0] da);
		logic [31:0] c;
		logic b;
		c = 32'hffff_ffff;
		for (int i = 0; i < 6; i++) begin
			for (int j = 0; j < 8; j++) begin
				b = c[31] ^ da[40 - 8 * i + j];
				c = {c[30:0], 1'b0} ^ (b ? 32'h04c1_1db7 : 32'h0);
			end
		end
		return c[31:26];
	endfunction : hash

	task send(input rfsmf_frame_type f, input logic k, input logic [15:0] s);
		int n;
		@(posedge pclk);
		req <= 1'b1;
		req_frm <= f;
		@(posedge pclk);
		req <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (frm_accept !== 1'b1 && frm_drop !== 1'b1 && n < 20);
		chk("accept", {31'h0, k}, {31'h0, frm_accept});
		chk("drop", {31'h0, !k}, {31'h0, frm_drop});
		if (frm_accept !== 1'b1 && frm_drop !== 1'b1)
			complete_run();
		if (k) begin
			chk("ready_held", 32'h0, {31'h0, frm_ready});
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk("status", {16'h0, s}, rd);
			apb(1'b0, ADDR_BYTE_COUNT, 32'h0);
			chk("byte_count", {21'h0, f.byte_count}, rd);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk("status_again", {16'h0, s}, rd);
			apb(1'b1, ADDR_RELEASE, 32'h1);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk("valid_clear", 32'h0, {31'h0, rd[ST_VALID]});
		end
	endtask : send

	task sc_regs;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status_rst", 32'h0, {31'h0, rd[ST_VALID]});
		for (int w = 0; w < 4; w++) begin
			apb(1'b0, ADDR_HASH0 + 12'(8 * w), 32'h0);
			chk("hash_rst", 32'h0, rd);
		end
		apb(1'b1, ADDR_HASH2, 32'hffff_a5c3);
		apb(1'b0, ADDR_HASH2, 32'h0);
		chk("hash_rw", 32'h0000_a5c3, rd);
		apb(1'b1, ADDR_HASH2, 32'h0);
		apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status_ro", 32'h0, rd);
		apb(1'b0, 12'h300, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, err});
	endtask : sc_regs

	task sc_class;
		rfsmf_frame_type f;
		f = mk(uc, 16'h0800, 11'h040, PORT_ONE, 1'b0, 1'b0);
		send(f, 1'b1, stat(f));
		f = mk(uc, 16'h05dc, 11'h77c, PORT_TWO, 1'b0, 1'b0);
		send(f, 1'b1, stat(f));
		f = mk(BCAST_DA, 16'h0800, 11'h040, PORT_TWO, 1'b0, 1'b0);
		send(f, 1'b1, stat(f));
	endtask : sc_class

	task sc_group;
		rfsmf_frame_type f;
		logic [5:0] h;
		logic [11:0] a;
		f = mk(gc, 16'h0800, 11'h040, PORT_ONE, 1'b0, 1'b0);
		h = hash(gc);
		a = ADDR_HASH0 + {7'h0, h[5:4], 3'h0};
		send(f, 1'b0, 16'h0);
		apb(1'b1, a ^ 12'h008, 32'h1 << h[3:0]);
		send(f, 1'b0, 16'h0);
		apb(1'b1, a ^ 12'h008, 32'h0);
		apb(1'b1, a, 32'h1 << h[3:0]);
		send(f, 1'b1, stat(f));
		apb(1'b1, a, 32'h0);
		apb(1'b1, ADDR_RX_CTRL, 32'h10);
		send(f, 1'b1, stat(f));
		apb(1'b1, ADDR_RX_CTRL, 32'h20);
		send(f, 1'b1, stat(f));
		apb(1'b1, ADDR_RX_CTRL, 32'h0);
		send(f, 1'b0, 16'h0);
	endtask : sc_group

	task sc_bad;
		rfsmf_frame_type f[3];
		f[0] = mk(uc, 16'h0800, 11'h020, PORT_ONE, 1'b1, 1'b0);
		f[1] = mk(uc, 16'h0800, 11'h040, PORT_TWO, 1'b0, 1'b1);
		f[2] = mk(uc, 16'h0800, 11'h77d, PORT_ONE, 1'b0, 1'b0);
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, ADDR_RX_CTRL, 32'h0);
			send(f[k], 1'b0, 16'h0);
			apb(1'b1, ADDR_RX_CTRL, 32'h200);
			send(f[k], 1'b1, stat(f[k]));
		end
	endtask : sc_bad

	// frame offered while the enable is low must wait, then be taken
	task sc_ce;
		int n;
		@(posedge pclk);
		req <= 1'b1;
		req_frm <= mk(uc, 16'h0800, 11'h040, PORT_ONE, 1'b0, 1'b0);
		ce <= 1'b0;
		@(posedge pclk);
		req <= 1'b0;
		repeat (4) @(posedge pclk);
		#1;
		chk("ce_frozen_pulse", 32'h0, {30'h0, frm_accept, frm_drop});
		chk("ce_frozen_ready", 32'h1, {31'h0, frm_ready});
		@(posedge pclk);
		ce <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			#1;
			n++;
		end while (frm_accept !== 1'b1 && n < 20);
		chk("ce_accept", 32'h1, {31'h0, frm_accept});
		if (frm_accept !== 1'b1)
			complete_run();
		apb(1'b1, ADDR_RELEASE, 32'h1);
	endtask : sc_ce

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		req = 1'b0;
		req_frm = '0;
		ce = 1'b1;
		fail_count = 0;
		checked = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		sc_regs();
		sc_class();
		sc_group();
		sc_bad();
		sc_ce();
		complete_run();
	end
endmodule : test_rx_frame_status_mcast_filter
